//--- verilog/hsopwm_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef HSOPWM_REGS_SVH
`define HSOPWM_REGS_SVH

// apb address width and register map
`define HSOPWM_AW 8
`define HSOPWM_GPO_ADDR 8'h40
`define HSOPWM_CH_AREA_BITS 2'h0
`define HSOPWM_SUB_CTRL 3'h0
`define HSOPWM_SUB_DUTY 3'h1
`define HSOPWM_SUB_FREQ 3'h2
`define HSOPWM_SUB_SDUTY 3'h3
`define HSOPWM_SUB_SFREQ 3'h4
`define HSOPWM_SUB_CMP1 3'h5
`define HSOPWM_SUB_CMP2 3'h6
`define HSOPWM_SUB_STAT 3'h7

// control register fields
`define HSOPWM_CTRL_W 8
`define HSOPWM_MODE_HI 1
`define HSOPWM_MODE_LO 0
`define HSOPWM_HOLD_BIT 2
`define HSOPWM_ACT1_HI 5
`define HSOPWM_ACT1_LO 4
`define HSOPWM_ACT2_HI 7
`define HSOPWM_ACT2_LO 6

// status register fields
`define HSOPWM_ST_OUT 0
`define HSOPWM_ST_ARMED 1
`define HSOPWM_ST_STOP 2
`define HSOPWM_ST_CMP 3

// reset values
`define HSOPWM_CTRL_RST 8'hf0
`define HSOPWM_WORD_RST 32'h0000_0000

// duty full scale and clock rate
`define HSOPWM_DUTY_FULL 32'h0000_7d00
`define HSOPWM_CLK_HZ 32'h05f5_e100

`endif

//--- verilog/hsopwm_pkg.sv
// types shared by the fast output modulator files
package hsopwm_pkg;

    // source selected for a channel pin
    typedef enum logic [1:0] {
        MODE_PLAIN,
        MODE_PWM,
        MODE_CMP,
        MODE_STEP
    } hsopwm_mode_t;

    // action taken on a compare hit
    typedef enum logic [1:0] {
        ACT_ON,
        ACT_OFF,
        ACT_TOGGLE,
        ACT_NONE
    } hsopwm_act_t;

    // one frequency and duty setting
    typedef struct packed {
        logic [31:0] freq;
        logic [31:0] duty;
    } hsopwm_wave_t;

endpackage

//--- verilog/hsopwm_gen.sv
// one modulation generator: period and high time counted in reference ticks
`timescale 1ns/1ps
`include "hsopwm_regs.svh"
module hsopwm_gen #(
    parameter logic [31:0] REF_HZ = `HSOPWM_CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire hsopwm_pkg::hsopwm_wave_t wave,
    output logic pwm_out
);

    logic [31:0] period_ff;
    logic [31:0] high_ff;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_period;
    logic [31:0] nxt_high;
    logic [63:0] prod;
    logic boundary;

    // new settings computed continuously, taken only at a boundary
    always_comb begin
        if (wave.freq == `HSOPWM_WORD_RST) begin
            nxt_period = 32'h0000_0001;
        end else if (wave.freq > REF_HZ) begin
            nxt_period = 32'h0000_0001;
        end else begin
            nxt_period = REF_HZ / wave.freq;
        end
        prod = nxt_period * wave.duty;
        if (wave.duty >= `HSOPWM_DUTY_FULL) begin
            nxt_high = nxt_period;
        end else if (wave.freq == `HSOPWM_WORD_RST) begin
            nxt_high = `HSOPWM_WORD_RST;
        end else begin
            nxt_high = 32'(prod / 64'(`HSOPWM_DUTY_FULL));
        end
    end

    assign boundary = tick && (cnt_ff >= period_ff - 32'h0000_0001);

    // period counter; reload at boundary so no pulse is cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= `HSOPWM_WORD_RST;
            period_ff <= 32'h0000_0001;
            high_ff <= `HSOPWM_WORD_RST;
        end else if (boundary) begin
            cnt_ff <= `HSOPWM_WORD_RST;
            period_ff <= nxt_period;
            high_ff <= nxt_high;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    // output high while count below high time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt_ff < high_ff);
        end
    end

endmodule

//--- verilog/hsopwm_top.sv
// two fast output channels with apb registers and per-channel sources
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "hsopwm_regs.svh"
module hsopwm_top #(
    parameter int REF_DIV = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`HSOPWM_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic controller_stop,
    input wire logic program_download,
    input wire logic [1:0][31:0] fast_pulse_counter,
    input wire logic [1:0] stepper_drive,
    output logic fast_output_first,
    output logic fast_output_second
);

    localparam int NCH = 2;
    localparam logic [31:0] REF_HZ = 32'(`HSOPWM_CLK_HZ / REF_DIV);
    localparam logic [15:0] DIV_LAST = 16'(REF_DIV - 1);

    // software visible state
    logic [`HSOPWM_CTRL_W-1:0] ctrl_ff [NCH];
    logic [31:0] pwm_duty_value_ff [NCH];
    logic [31:0] pwm_frequency_hz_ff [NCH];
    logic [31:0] stop_duty_ff [NCH];
    logic [31:0] stop_freq_ff [NCH];
    logic [31:0] compare_value_first_ff [NCH];
    logic [31:0] compare_value_second_ff [NCH];
    logic [NCH-1:0] plain_output_bit_ff;

    // internal channel state
    logic [NCH-1:0] armed_ff;
    logic [NCH-1:0] cmp_state_ff;
    logic [NCH-1:0] hit1_prev_ff;
    logic [NCH-1:0] hit2_prev_ff;
    logic [NCH-1:0] out_ff;
    logic [NCH-1:0] gen_out;
    logic [NCH-1:0] hit1;
    logic [NCH-1:0] hit2;
    logic [NCH-1:0] pwm_allow;
    hsopwm_pkg::hsopwm_wave_t frozen_ff [NCH];
    hsopwm_pkg::hsopwm_wave_t run_wave [NCH];
    hsopwm_pkg::hsopwm_wave_t sel_wave [NCH];
    logic stop_prev_ff;
    logic [15:0] div_ff;
    logic tick;
    logic [31:0] prdata_ff;

    // address decode
    logic ch_area;
    logic gpo_hit;
    logic addr_ok;
    logic ch_idx;
    logic [2:0] sub;
    logic wr_en;
    logic [31:0] nxt_prdata;

    assign ch_area = (paddr[`HSOPWM_AW-1:`HSOPWM_AW-2]
                      == `HSOPWM_CH_AREA_BITS);
    assign gpo_hit = (paddr == `HSOPWM_GPO_ADDR);
    assign addr_ok = (ch_area || gpo_hit) && (paddr[1:0] == 2'h0);
    assign ch_idx = paddr[5];
    assign sub = paddr[4:2];

    // zero wait state slave; unmapped words answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign prdata = prdata_ff;

    // reference tick divider
    assign tick = (div_ff == DIV_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 16'h0000;
        end else if (tick) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_ff[i] <= `HSOPWM_CTRL_RST;
                pwm_duty_value_ff[i] <= `HSOPWM_WORD_RST;
                pwm_frequency_hz_ff[i] <= `HSOPWM_WORD_RST;
                stop_duty_ff[i] <= `HSOPWM_WORD_RST;
                stop_freq_ff[i] <= `HSOPWM_WORD_RST;
                compare_value_first_ff[i] <= `HSOPWM_WORD_RST;
                compare_value_second_ff[i] <= `HSOPWM_WORD_RST;
            end
            plain_output_bit_ff <= 2'h0;
        end else if (wr_en) begin
            if (gpo_hit) begin
                plain_output_bit_ff <= pwdata[NCH-1:0];
            end else begin
                unique case (sub)
                    `HSOPWM_SUB_CTRL: begin
                        ctrl_ff[ch_idx] <= pwdata[`HSOPWM_CTRL_W-1:0];
                    end
                    `HSOPWM_SUB_DUTY: begin
                        pwm_duty_value_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_FREQ: begin
                        pwm_frequency_hz_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_SDUTY: begin
                        stop_duty_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_SFREQ: begin
                        stop_freq_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_CMP1: begin
                        compare_value_first_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_CMP2: begin
                        compare_value_second_ff[ch_idx] <= pwdata;
                    end
                    `HSOPWM_SUB_STAT: begin
                        // status is read only
                    end
                endcase
            end
        end
    end

    // read mux, sampled in the setup cycle
    always_comb begin
        nxt_prdata = `HSOPWM_WORD_RST;
        if (gpo_hit) begin
            nxt_prdata[NCH-1:0] = plain_output_bit_ff;
        end else if (ch_area && addr_ok) begin
            unique case (sub)
                `HSOPWM_SUB_CTRL: begin
                    nxt_prdata[`HSOPWM_CTRL_W-1:0] = ctrl_ff[ch_idx];
                end
                `HSOPWM_SUB_DUTY: begin
                    nxt_prdata = pwm_duty_value_ff[ch_idx];
                end
                `HSOPWM_SUB_FREQ: begin
                    nxt_prdata = pwm_frequency_hz_ff[ch_idx];
                end
                `HSOPWM_SUB_SDUTY: begin
                    nxt_prdata = stop_duty_ff[ch_idx];
                end
                `HSOPWM_SUB_SFREQ: begin
                    nxt_prdata = stop_freq_ff[ch_idx];
                end
                `HSOPWM_SUB_CMP1: begin
                    nxt_prdata = compare_value_first_ff[ch_idx];
                end
                `HSOPWM_SUB_CMP2: begin
                    nxt_prdata = compare_value_second_ff[ch_idx];
                end
                `HSOPWM_SUB_STAT: begin
                    nxt_prdata[`HSOPWM_ST_OUT] = out_ff[ch_idx];
                    nxt_prdata[`HSOPWM_ST_ARMED] = armed_ff[ch_idx];
                    nxt_prdata[`HSOPWM_ST_STOP] = controller_stop;
                    nxt_prdata[`HSOPWM_ST_CMP] = cmp_state_ff[ch_idx];
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `HSOPWM_WORD_RST;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // stop entry detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_prev_ff <= 1'b0;
        end else begin
            stop_prev_ff <= controller_stop;
        end
    end

    // per-channel generator, stop policy, compare and output select
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        hsopwm_pkg::hsopwm_mode_t mode;
        hsopwm_pkg::hsopwm_act_t act1;
        hsopwm_pkg::hsopwm_act_t act2;
        logic hold;

        assign mode = hsopwm_pkg::hsopwm_mode_t'(
            ctrl_ff[c][`HSOPWM_MODE_HI:`HSOPWM_MODE_LO]);
        assign act1 = hsopwm_pkg::hsopwm_act_t'(
            ctrl_ff[c][`HSOPWM_ACT1_HI:`HSOPWM_ACT1_LO]);
        assign act2 = hsopwm_pkg::hsopwm_act_t'(
            ctrl_ff[c][`HSOPWM_ACT2_HI:`HSOPWM_ACT2_LO]);
        assign hold = ctrl_ff[c][`HSOPWM_HOLD_BIT];

        assign run_wave[c].freq = pwm_frequency_hz_ff[c];
        assign run_wave[c].duty = pwm_duty_value_ff[c];

        // in stop: frozen waveform or the stop pair; run values until frozen
        always_comb begin
            if (!controller_stop || (hold && !stop_prev_ff)) begin
                sel_wave[c] = run_wave[c];
            end else if (hold) begin
                sel_wave[c] = frozen_ff[c];
            end else begin
                sel_wave[c].freq = stop_freq_ff[c];
                sel_wave[c].duty = stop_duty_ff[c];
            end
        end

        // waveform captured as stop begins
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                frozen_ff[c] <= '0;
            end else if (controller_stop && !stop_prev_ff) begin
                frozen_ff[c] <= run_wave[c];
            end
        end

        // armed once both run values are non-zero; cleared by download
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                armed_ff[c] <= 1'b0;
            end else if (program_download) begin
                armed_ff[c] <= 1'b0;
            end else if (pwm_frequency_hz_ff[c] != `HSOPWM_WORD_RST &&
                         pwm_duty_value_ff[c] != `HSOPWM_WORD_RST) begin
                armed_ff[c] <= 1'b1;
            end
        end

        // modulated output allowed only when armed, not downloading, and, in stop without hold, stop pair valid
        always_comb begin
            pwm_allow[c] = armed_ff[c] && !program_download;
            if (controller_stop && !hold &&
                (stop_freq_ff[c] == `HSOPWM_WORD_RST ||
                 stop_duty_ff[c] == `HSOPWM_WORD_RST)) begin
                pwm_allow[c] = 1'b0;
            end
        end

        hsopwm_gen #(
            .REF_HZ(REF_HZ)
        ) u_gen (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick),
            .wave(sel_wave[c]),
            .pwm_out(gen_out[c])
        );

        // compare hits act on the cycle equality begins
        assign hit1[c] = (fast_pulse_counter[c] == compare_value_first_ff[c]);
        assign hit2[c] = (fast_pulse_counter[c] == compare_value_second_ff[c]);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hit1_prev_ff[c] <= 1'b0;
                hit2_prev_ff[c] <= 1'b0;
            end else begin
                hit1_prev_ff[c] <= hit1[c];
                hit2_prev_ff[c] <= hit2[c];
            end
        end

        // compare output state; second compare wins a tie unless act2 is ACT_NONE
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmp_state_ff[c] <= 1'b0;
            end else if (hit2[c] && !hit2_prev_ff[c] &&
                         act2 != hsopwm_pkg::ACT_NONE) begin
                unique case (act2)
                    hsopwm_pkg::ACT_ON: begin
                        cmp_state_ff[c] <= 1'b1;
                    end
                    hsopwm_pkg::ACT_OFF: begin
                        cmp_state_ff[c] <= 1'b0;
                    end
                    default: begin
                        cmp_state_ff[c] <= !cmp_state_ff[c];
                    end
                endcase
            end else if (hit1[c] && !hit1_prev_ff[c]) begin
                unique case (act1)
                    hsopwm_pkg::ACT_ON: begin
                        cmp_state_ff[c] <= 1'b1;
                    end
                    hsopwm_pkg::ACT_OFF: begin
                        cmp_state_ff[c] <= 1'b0;
                    end
                    hsopwm_pkg::ACT_TOGGLE: begin
                        cmp_state_ff[c] <= !cmp_state_ff[c];
                    end
                    hsopwm_pkg::ACT_NONE: begin
                        cmp_state_ff[c] <= cmp_state_ff[c];
                    end
                endcase
            end
        end

        // pin source select
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_ff[c] <= 1'b0;
            end else begin
                unique case (mode)
                    hsopwm_pkg::MODE_PLAIN: begin
                        out_ff[c] <= plain_output_bit_ff[c];
                    end
                    hsopwm_pkg::MODE_PWM: begin
                        out_ff[c] <= gen_out[c] && pwm_allow[c];
                    end
                    hsopwm_pkg::MODE_CMP: begin
                        out_ff[c] <= cmp_state_ff[c];
                    end
                    hsopwm_pkg::MODE_STEP: begin
                        out_ff[c] <= stepper_drive[c] && !controller_stop;
                    end
                endcase
            end
        end
    end

    assign fast_output_first = out_ff[0];
    assign fast_output_second = out_ff[1];

endmodule

//--- verif/hsopwm_load.sv
// load model: measures the high time and period seen on one pin
`timescale 1ns/1ps
module hsopwm_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic [15:0] high_len,
    output logic [15:0] per_len,
    output logic [15:0] rises
);
    logic pin_q_ff;
    logic [15:0] hi_ff;
    logic [15:0] per_ff;

    // count high cycles and cycles between rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q_ff <= 1'b0;
            hi_ff <= 16'h0;
            per_ff <= 16'h0;
            high_len <= 16'h0;
            per_len <= 16'h0;
            rises <= 16'h0;
        end else begin
            pin_q_ff <= pin;
            per_ff <= per_ff + 16'h1;
            if (pin) begin
                hi_ff <= hi_ff + 16'h1;
            end
            if (pin && !pin_q_ff) begin
                per_len <= per_ff;
                per_ff <= 16'h1;
                hi_ff <= 16'h1;
                rises <= rises + 16'h1;
            end
            if (!pin && pin_q_ff) begin
                high_len <= hi_ff;
            end
        end
    end
endmodule

//--- verif/hsopwm_monitor.sv
// checker on the fast output block's ports
`timescale 1ns/1ps
`include "hsopwm_regs.svh"
module hsopwm_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`HSOPWM_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic controller_stop,
    input wire logic program_download,
    input wire logic [1:0][31:0] fast_pulse_counter,
    input wire logic [1:0] stepper_drive,
    input wire logic fast_output_first,
    input wire logic fast_output_second
);
    // settle span assumes run periods of at most 300 cycles
    localparam logic [15:0] SETTLE = 16'h190;
    logic wr_acc;
    logic [1:0] mode1_ff;
    logic hold1_ff;
    logic [31:0] duty1_ff;
    logic [31:0] freq1_ff;
    logic [31:0] sduty1_ff;
    logic [15:0] steady_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign wr_acc = psel && penable && pwrite && pready;

    // shadow of channel one control, run words and stop duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode1_ff <= 2'h0;
            hold1_ff <= 1'b0;
            duty1_ff <= 32'h0;
            freq1_ff <= 32'h0;
            sduty1_ff <= 32'h0;
        end else if (wr_acc) begin
            case (paddr)
                8'h00: begin
                    mode1_ff <= pwdata[1:0];
                    hold1_ff <= pwdata[`HSOPWM_HOLD_BIT];
                end
                8'h04: duty1_ff <= pwdata;
                8'h08: freq1_ff <= pwdata;
                8'h0c: sduty1_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // cycles of undisturbed run modulation on channel one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steady_ff <= 16'h0;
        end else if (mode1_ff != hsopwm_pkg::MODE_PWM || controller_stop
                     || program_download || (wr_acc && paddr < 8'h20)) begin
            steady_ff <= 16'h0;
        end else if (steady_ff != SETTLE) begin
            steady_ff <= steady_ff + 16'h1;
        end
    end

    sequence s_gpo_write;
        wr_acc && paddr == `HSOPWM_GPO_ADDR;
    endsequence

    a_plain_follow: assert property (
        s_gpo_write ##0 mode1_ff == hsopwm_pkg::MODE_PLAIN |=> ##1
        fast_output_first == $past(pwdata[0], 2))
        else $error("plain pin did not follow output bit");
    a_full_on: assert property (
        steady_ff == SETTLE && duty1_ff == `HSOPWM_DUTY_FULL
        && freq1_ff != 32'h0 |-> fast_output_first)
        else $error("full duty pin not high");
    a_zero_off: assert property (
        steady_ff == SETTLE && duty1_ff == 32'h0 |-> !fast_output_first)
        else $error("zero duty pin not low");
    a_stop_zero: assert property (
        (controller_stop && !hold1_ff && sduty1_ff == 32'h0
        && mode1_ff == hsopwm_pkg::MODE_PWM)[*4] |-> !fast_output_first)
        else $error("zero stop pair pin not low");
    a_dl_off: assert property (
        (program_download && mode1_ff == hsopwm_pkg::MODE_PWM)[*3]
        |-> !fast_output_first)
        else $error("download pin not low");
    a_err_bad: assert property (
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_data: assert property (
        psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_step_pass: assert property (
        mode1_ff == hsopwm_pkg::MODE_STEP && !controller_stop
        && !program_download |=> fast_output_first == $past(stepper_drive[0]))
        else $error("stepper pin not passed through");
endmodule

//--- verif/high_speed_output_pwm_tb.sv
// self-checking bench for the two-channel fast output block
`timescale 1ns/1ps
`include "hsopwm_regs.svh"
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("BAD %0t got %0h exp %0h", $time, got, exp); \
        end \
    end
module high_speed_output_pwm_tb;
    typedef struct {
        logic [31:0] d;
        logic [31:0] f;
        logic [15:0] h;
        logic [15:0] p;
    } hsopwm_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stop = 1'b0;
    logic dl = 1'b0;
    logic [1:0][31:0] cnt = 64'h0;
    logic [1:0] step = 2'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic out1;
    logic out2;
    logic [15:0] l_hi;
    logic [15:0] l_per;
    logic [15:0] l_rise;
    logic [15:0] r0;
    logic [31:0] q;
    logic e;
    int failures = 0;
    int compares = 0;
    // duty, frequency, high cycles, period (0: steady level)
    hsopwm_row_t rows [6] = '{
        '{32'h1f40, 32'h000f_4240, 16'h19, 16'h64},
        '{32'h3e80, 32'h000f_4240, 16'h32, 16'h64},
        '{32'h7080, 32'h0007_a120, 16'hb4, 16'hc8},
        '{`HSOPWM_DUTY_FULL, 32'h000f_4240, 16'h1, 16'h0},
        '{32'h0, 32'h000f_4240, 16'h0, 16'h0},
        '{32'h1f40, 32'h000f_4240, 16'h19, 16'h64}};

    // 100 MHz clock
    always #5 pclk = ~pclk;

    hsopwm_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .controller_stop(stop),
        .program_download(dl), .fast_pulse_counter(cnt),
        .stepper_drive(step), .fast_output_first(out1),
        .fast_output_second(out2));

    hsopwm_load i_load (
        .pclk(pclk), .presetn(presetn), .pin(out1), .high_len(l_hi),
        .per_len(l_per), .rises(l_rise));

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // sweep both accumulators from zero upward
    task automatic ramp(input int n);
        for (int i = 0; i < n; i++) begin
            cnt <= {2{32'(i)}};
            @(posedge pclk);
        end
    endtask

    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(q, {24'h0, `HSOPWM_CTRL_RST})
        apb(1'b1, 8'h06, 32'h1);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h02, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b0, 8'h44, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b0, 8'h04, 32'h0);
        `CHK(q, 32'h0)
        $display("test done: reset");
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h3e80);
        cyc(300);
        `CHK({out1, l_rise}, 17'h0)
        $display("test done: arming");
        foreach (rows[i]) begin
            apb(1'b1, 8'h04, rows[i].d);
            apb(1'b1, 8'h08, rows[i].f);
            cyc(600);
            r0 = l_rise;
            cyc(300);
            if (rows[i].p != 16'h0) begin
                `CHK({l_hi, l_per}, {rows[i].h, rows[i].p})
            end else begin
                `CHK({out1, l_rise}, {rows[i].h[0], r0})
            end
        end
        $display("test done: table");
        stop <= 1'b1;
        cyc(10);
        r0 = l_rise;
        cyc(300);
        `CHK({out1, l_rise}, {1'b0, r0})
        apb(1'b1, 8'h0c, 32'h5dc0);
        apb(1'b1, 8'h10, 32'h000f_4240);
        cyc(600);
        `CHK({l_hi, l_per}, {16'h4b, 16'h64})
        stop <= 1'b0;
        apb(1'b1, 8'h00, 32'h5);
        stop <= 1'b1;
        cyc(600);
        `CHK({l_hi, l_per}, {16'h19, 16'h64})
        stop <= 1'b0;
        dl <= 1'b1;
        cyc(10);
        r0 = l_rise;
        cyc(300);
        `CHK({out1, l_rise}, {1'b0, r0})
        dl <= 1'b0;
        $display("test done: stop and download");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b1, `HSOPWM_GPO_ADDR, 32'h2);
        cyc(2);
        `CHK({out1, out2}, 2'h1)
        apb(1'b1, `HSOPWM_GPO_ADDR, 32'h1);
        cyc(2);
        `CHK({out1, out2}, 2'h2)
        apb(1'b1, 8'h34, 32'ha);
        apb(1'b1, 8'h38, 32'h14);
        apb(1'b1, 8'h20, 32'h42);
        ramp(16);
        `CHK(out2, 1'b1)
        ramp(30);
        `CHK(out2, 1'b0)
        apb(1'b1, 8'h20, 32'he2);
        ramp(16);
        `CHK(out2, 1'b1)
        ramp(16);
        `CHK(out2, 1'b0)
        apb(1'b1, 8'h00, 32'h3);
        step <= 2'h1;
        cyc(3);
        `CHK(out1, 1'b1)
        stop <= 1'b1;
        cyc(3);
        `CHK(out1, 1'b0)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK(q, 32'he)
        stop <= 1'b0;
        $display("test done: sources");
        final_report;
    end

    // watchdog: the tests need about 7.7k cycles
    initial begin
        #400000;
        failures++;
        final_report;
    end
endmodule

bind hsopwm_top hsopwm_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .controller_stop(controller_stop),
    .program_download(program_download),
    .fast_pulse_counter(fast_pulse_counter), .stepper_drive(stepper_drive),
    .fast_output_first(fast_output_first),
    .fast_output_second(fast_output_second));
